/* shared/dcwd_pkg.sv */
// package for the drive command word decoder
// assumes a single 50 MHz clock shared by every user of these constants
`default_nettype none
package dcwd_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// control cycle period and its length in clocks
	localparam int CTRL_CYCLE_NS = 10000;
	localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;

	// object dictionary indexes
	localparam logic [15:0] IDX_CMD_WORD = 16'h6040;
	localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
	localparam logic [15:0] CMD_WORD_RST = 16'h0000;

	// command word bit positions
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_EN_VOLT = 1;
	localparam int CW_QSTOP_N = 2;
	localparam int CW_EN_OP = 3;
	localparam int CW_NEW_SP = 4;
	localparam int CW_CHG_IMM = 5;
	localparam int CW_REL = 6;
	localparam int CW_FLT_RST = 7;
	localparam int CW_HALT = 8;
	localparam int CW_LIFE = 15;

	// state word bit positions
	localparam int SW_VOLT_EN = 4;
	localparam int SW_LIFE = 15;

	// state bits 0..3,5,6 with bit 4 cleared (voltage filled in live)
	localparam logic [6:0] SW_NOT_READY = 7'h00;
	localparam logic [6:0] SW_SO_DIS = 7'h40;
	localparam logic [6:0] SW_READY = 7'h21;
	localparam logic [6:0] SW_SWITCHED = 7'h23;
	localparam logic [6:0] SW_OP_EN = 7'h27;
	localparam logic [6:0] SW_QS_ACT = 7'h07;
	localparam logic [6:0] SW_FLT_REACT = 7'h0f;
	localparam logic [6:0] SW_FAULT = 7'h08;

	typedef enum logic [2:0] {
		ST_NOT_READY,
		ST_SO_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QS_ACTIVE,
		ST_FAULT_REACT,
		ST_FAULT
	} dcwd_state_e;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SHUT_DOWN,
		CMD_SWITCH_ON,
		CMD_DIS_VOLT,
		CMD_QUICK_STOP,
		CMD_EN_OP
	} dcwd_cmd_e;
endpackage : dcwd_pkg
`default_nettype wire

/* rtl/dcwd_cycle_timer.sv */
// control cycle tick generator: one-clock pulse every PERIOD clocks
// assumes a synchronised active-low reset
`default_nettype none
module dcwd_cycle_timer
	import dcwd_pkg::*;
#(
	parameter int PERIOD = CTRL_CYCLE_CLKS
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// tick
	output logic tick_out
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 16'h0000;
			tick_out <= 1'b0;
		end else if (cnt_q == 16'(PERIOD - 1)) begin
			cnt_q <= 16'h0000;
			tick_out <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule : dcwd_cycle_timer
`default_nettype wire

/* rtl/dcwd_decoder.sv */
// drive command word decoder and drive power state machine
// assumes object dictionary accesses arrive synchronous to ref_clk_in
`default_nettype none
// Contract
// - bits 0-3 decode into the device commands
// - shut down leaves switch-on-disabled for ready
// - switch on moves ready to switched on
// - enable operation moves switched on onward
// - enable operation from ready lands enabled
// - fault reset edge returns fault to disabled
// - fault reset acts on rising edge only
// - quick stop ramps down then holds position if profile_pos_in
// - quick stop left only by disable voltage; the code also leaves it for fault reaction on a detected error
// - bit 4 flags a new target position
// - bit 5 ignored, jobs start at once
// - bit 6 selects absolute or relative target
// - halt bit stops, clearing resumes jobs
// - life bit mirrored into state word
// - undefined commands cause no state change
// - state word bits 0-6 show state
// - state word encoding per state
// - disable voltage drops output stage, no braking
// - enabled error forces stop then fault
module dcwd_decoder
	import dcwd_pkg::*;
#(
	parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// object dictionary access
	input wire logic obj_wr_in,
	input wire logic obj_rd_in,
	input wire logic [15:0] obj_index_in,
	input wire logic [15:0] obj_wdata_in,
	output logic [15:0] obj_rdata_out,
	output logic obj_rvalid_out,
	// drive status inputs
	input wire logic fault_detect_in,
	input wire logic motor_stopped_in,
	input wire logic supply_ok_in,
	input wire logic profile_pos_in,
	// drive control outputs
	output logic [15:0] state_word_out,
	output logic stage_enable_out,
	output logic qs_ramp_out,
	output logic hold_pos_out,
	output logic fault_stop_out,
	output logic halt_out,
	output logic new_setpoint_out,
	output logic relative_out,
	output logic start_job_out,
	output logic cancel_jobs_out
);
	logic rst_meta_q;
	logic rst_n_q;
	logic tick;
	logic [15:0] cmd_word_q;
	logic flt_rst_prev_q;
	logic new_sp_prev_q;
	logic life_q;
	dcwd_state_e st_q;
	dcwd_state_e st_d;
	dcwd_cmd_e cmd;
	logic flt_rst_edge;

	// reset release through two flops
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	dcwd_cycle_timer #(
		.PERIOD(CYCLE_CLKS)
	) u_timer (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n_q),
		.tick_out(tick)
	);

	function automatic dcwd_cmd_e decode_cmd(input logic [3:0] b);
		// disable voltage outranks quick stop, which outranks the rest
		if (!b[CW_EN_VOLT])
			return CMD_DIS_VOLT;
		else if (!b[CW_QSTOP_N])
			return CMD_QUICK_STOP;
		else if (!b[CW_SWITCH_ON])
			return CMD_SHUT_DOWN;
		else if (!b[CW_EN_OP])
			return CMD_SWITCH_ON;
		else
			return CMD_EN_OP;
	endfunction : decode_cmd

	function automatic logic [6:0] state_bits(input dcwd_state_e s);
		case (s)
			ST_NOT_READY: return SW_NOT_READY;
			ST_SO_DISABLED: return SW_SO_DIS;
			ST_READY: return SW_READY;
			ST_SWITCHED_ON: return SW_SWITCHED;
			ST_OP_ENABLED: return SW_OP_EN;
			ST_QS_ACTIVE: return SW_QS_ACT;
			ST_FAULT_REACT: return SW_FLT_REACT;
			ST_FAULT: return SW_FAULT;
			default: return SW_NOT_READY;
		endcase
	endfunction : state_bits

	// command word store; every bit kept, including the unused ones
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q)
			cmd_word_q <= CMD_WORD_RST;
		else if (obj_wr_in && obj_index_in == IDX_CMD_WORD)
			cmd_word_q <= obj_wdata_in;
	end

	// read port; state word is read-only, writes to it are dropped
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			obj_rdata_out <= 16'h0000;
			obj_rvalid_out <= 1'b0;
		end else begin
			obj_rvalid_out <= obj_rd_in;
			if (!obj_rd_in)
				obj_rdata_out <= 16'h0000;
			else if (obj_index_in == IDX_CMD_WORD)
				obj_rdata_out <= cmd_word_q;
			else if (obj_index_in == IDX_STATE_WORD)
				obj_rdata_out <= state_word_out;
			else
				obj_rdata_out <= 16'h0000;
		end
	end

	assign cmd = decode_cmd(cmd_word_q[3:0]);
	assign flt_rst_edge = cmd_word_q[CW_FLT_RST] && !flt_rst_prev_q;

	// edge history is taken per sample, so a pulse inside one cycle is missed
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flt_rst_prev_q <= 1'b0;
			new_sp_prev_q <= 1'b0;
			life_q <= 1'b0;
		end else if (tick) begin
			flt_rst_prev_q <= cmd_word_q[CW_FLT_RST];
			new_sp_prev_q <= cmd_word_q[CW_NEW_SP];
			life_q <= cmd_word_q[CW_LIFE];
		end
	end

	// next state; only the transitions defined for st_q exist
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_NOT_READY:
				st_d = ST_SO_DISABLED;
			ST_SO_DISABLED:
				if (cmd == CMD_SHUT_DOWN)
					st_d = ST_READY;
			ST_READY: begin
				case (cmd)
					CMD_SWITCH_ON: st_d = ST_SWITCHED_ON;
					CMD_EN_OP: if (supply_ok_in) st_d = ST_OP_ENABLED;
					CMD_DIS_VOLT: st_d = ST_SO_DISABLED;
					CMD_QUICK_STOP: st_d = ST_SO_DISABLED;
					default: st_d = st_q;
				endcase
			end
			ST_SWITCHED_ON: begin
				case (cmd)
					CMD_EN_OP: if (supply_ok_in) st_d = ST_OP_ENABLED;
					CMD_SHUT_DOWN: st_d = ST_READY;
					CMD_DIS_VOLT: st_d = ST_SO_DISABLED;
					CMD_QUICK_STOP: st_d = ST_SO_DISABLED;
					default: st_d = st_q;
				endcase
			end
			ST_OP_ENABLED: begin
				case (cmd)
					CMD_SWITCH_ON: st_d = ST_SWITCHED_ON;
					CMD_SHUT_DOWN: st_d = ST_READY;
					CMD_DIS_VOLT: st_d = ST_SO_DISABLED;
					CMD_QUICK_STOP: st_d = ST_QS_ACTIVE;
					default: st_d = st_q;
				endcase
			end
			ST_QS_ACTIVE:
				if (cmd == CMD_DIS_VOLT)
					st_d = ST_SO_DISABLED;
			ST_FAULT_REACT:
				if (motor_stopped_in)
					st_d = ST_FAULT;
			ST_FAULT:
				if (flt_rst_edge)
					st_d = ST_SO_DISABLED;
			default:
				st_d = ST_NOT_READY;
		endcase
		// a detected error overrides any command from normal states
		if (fault_detect_in && st_q != ST_FAULT_REACT && st_q != ST_FAULT)
			st_d = ST_FAULT_REACT;
	end

	// one evaluation per control cycle sample
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q)
			st_q <= ST_NOT_READY;
		else if (tick)
			st_q <= st_d;
	end

	// output stage and stop control
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stage_enable_out <= 1'b0;
			qs_ramp_out <= 1'b0;
			hold_pos_out <= 1'b0;
			fault_stop_out <= 1'b0;
		end else begin
			// stage stays on while braking in fault reaction
			stage_enable_out <= st_q == ST_OP_ENABLED || st_q == ST_QS_ACTIVE
				|| st_q == ST_FAULT_REACT;
			qs_ramp_out <= st_q == ST_QS_ACTIVE && !motor_stopped_in;
			hold_pos_out <= st_q == ST_QS_ACTIVE && motor_stopped_in && profile_pos_in;
			fault_stop_out <= st_q == ST_FAULT_REACT;
		end
	end

	// motion qualifiers, meaningful only in operation enabled
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			halt_out <= 1'b0;
			new_setpoint_out <= 1'b0;
			relative_out <= 1'b0;
			start_job_out <= 1'b0;
			cancel_jobs_out <= 1'b0;
		end else begin
			halt_out <= cmd_word_q[CW_HALT];
			new_setpoint_out <= cmd_word_q[CW_NEW_SP];
			relative_out <= cmd_word_q[CW_REL];
			// change-immediately bit is never consulted
			start_job_out <= tick && st_q == ST_OP_ENABLED && st_d == ST_OP_ENABLED
				&& cmd_word_q[CW_NEW_SP] && !new_sp_prev_q;
			cancel_jobs_out <= tick && st_q == ST_OP_ENABLED && st_d != ST_OP_ENABLED;
		end
	end

	// state word
	always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
		if (!rst_n_q)
			state_word_out <= 16'h0000;
		else begin
			state_word_out <= 16'h0000;
			state_word_out[6:0] <= state_bits(st_q);
			state_word_out[SW_VOLT_EN] <= stage_enable_out;
			state_word_out[SW_LIFE] <= life_q;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_q);

	chk_shutdown_ready: assert property (tick && st_q == ST_SO_DISABLED && cmd_word_q[3:0] == 4'h6
		&& !fault_detect_in |=> st_q == ST_READY)
		else $error("shut down did not reach ready");
	chk_switch_on: assert property (tick && st_q == ST_READY && cmd_word_q[3:0] == 4'h7
		&& !fault_detect_in |=> st_q == ST_SWITCHED_ON)
		else $error("switch on did not reach switched on");
	chk_enable_op: assert property (tick && (st_q == ST_SWITCHED_ON || st_q == ST_READY)
		&& cmd_word_q[3:0] == 4'hf && supply_ok_in && !fault_detect_in |=> st_q == ST_OP_ENABLED)
		else $error("enable operation failed");
	chk_fault_reset: assert property (tick && st_q == ST_FAULT && cmd_word_q[CW_FLT_RST]
		&& !flt_rst_prev_q |=> st_q == ST_SO_DISABLED)
		else $error("fault reset edge ignored");
	chk_fault_level: assert property (tick && st_q == ST_FAULT && flt_rst_prev_q
		|=> st_q == ST_FAULT)
		else $error("fault left on steady reset level");
	chk_qs_stays: assert property (tick && st_q == ST_QS_ACTIVE && cmd_word_q[CW_EN_VOLT]
		&& !fault_detect_in |=> st_q == ST_QS_ACTIVE)
		else $error("quick stop left without disable voltage");
	chk_qs_leave: assert property (tick && st_q == ST_QS_ACTIVE && !cmd_word_q[CW_EN_VOLT]
		&& !fault_detect_in |=> st_q == ST_SO_DISABLED)
		else $error("disable voltage did not end quick stop");
	chk_error_react: assert property (tick && fault_detect_in && st_q != ST_FAULT
		&& st_q != ST_FAULT_REACT |=> st_q == ST_FAULT_REACT ##1 fault_stop_out)
		else $error("error not reacted to");
	chk_sample_only: assert property (!tick |=> $stable(st_q))
		else $error("state moved between samples");
	chk_life_mirror: assert property (tick |-> ##2 state_word_out[SW_LIFE] == $past(cmd_word_q[CW_LIFE], 2))
		else $error("life bit not mirrored");
	chk_op_bits: assert property (st_q == ST_OP_ENABLED ##1 st_q == ST_OP_ENABLED
		|=> state_word_out[6:0] == 7'h37)
		else $error("operation enabled encoding wrong");
	chk_stage_off: assert property (st_q == ST_SO_DISABLED |=> !stage_enable_out)
		else $error("stage on in switch on disabled");
	chk_volt_off: assert property (tick && st_q == ST_OP_ENABLED && !cmd_word_q[CW_EN_VOLT]
		&& !fault_detect_in |=> st_q == ST_SO_DISABLED ##1 !stage_enable_out)
		else $error("disable voltage left stage on");
	chk_qs_entry: assert property (tick && st_q == ST_OP_ENABLED && cmd_word_q[CW_EN_VOLT]
		&& !cmd_word_q[CW_QSTOP_N] && !fault_detect_in |=> st_q == ST_QS_ACTIVE)
		else $error("quick stop not entered");
	chk_qs_ramp: assert property (st_q == ST_QS_ACTIVE && !motor_stopped_in
		|=> qs_ramp_out)
		else $error("quick stop ramp not applied");
	chk_invalid_hold: assert property (tick && st_q == ST_SO_DISABLED && cmd_word_q[2:0] != 3'h6
		&& !fault_detect_in |=> st_q == ST_SO_DISABLED)
		else $error("invalid command changed state");
	chk_cmd_store: assert property (obj_wr_in && obj_index_in == IDX_CMD_WORD
		|=> cmd_word_q == $past(obj_wdata_in))
		else $error("command word not stored");
	chk_state_ro: assert property (obj_wr_in && obj_index_in == IDX_STATE_WORD
		|=> $stable(cmd_word_q))
		else $error("state word write disturbed command word");
	chk_halt_bit: assert property (obj_wr_in && obj_index_in == IDX_CMD_WORD
		|-> ##2 halt_out == $past(obj_wdata_in[CW_HALT], 2))
		else $error("halt bit not followed");
	chk_setpoint_bit: assert property (obj_wr_in && obj_index_in == IDX_CMD_WORD
		|-> ##2 new_setpoint_out == $past(obj_wdata_in[CW_NEW_SP], 2))
		else $error("new set-point bit not followed");
	chk_rel_bit: assert property (obj_wr_in && obj_index_in == IDX_CMD_WORD
		|-> ##2 relative_out == $past(obj_wdata_in[CW_REL], 2))
		else $error("relative bit not followed");
	chk_start_job: assert property (start_job_out
		|-> st_q == ST_OP_ENABLED && $past(cmd_word_q[CW_NEW_SP]))
		else $error("job started without new set-point");

	cov_op_enabled: cover property (st_q == ST_SWITCHED_ON ##[1:600] st_q == ST_OP_ENABLED);
	cov_direct_enable: cover property (st_q == ST_READY ##1 st_q == ST_READY ##[1:600] st_q == ST_OP_ENABLED);
	cov_quick_stop: cover property (st_q == ST_QS_ACTIVE ##[1:600] st_q == ST_SO_DISABLED);
	cov_fault_reset: cover property (st_q == ST_FAULT ##[1:600] st_q == ST_SO_DISABLED);
endmodule : dcwd_decoder
`default_nettype wire

/* tb/dcwd_master_model.sv */
// network master model: writes and reads drive objects over the object bus
// assumes the decoder samples strobes on rising edges of clk_in
`default_nettype none
module dcwd_master_model
	import dcwd_pkg::*;
(
	// clock
	input wire logic clk_in,
	// object bus
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] idx_out,
	output logic [15:0] wdata_out,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		idx_out = 16'h0000;
		wdata_out = 16'h0000;
	end

	// released lines show the inverse so stale values cannot pass as valid
	task automatic wr_obj(input logic [15:0] idx, input logic [15:0] data);
		@(negedge clk_in);
		wr_out = 1'b1;
		idx_out = idx;
		wdata_out = data;
		@(negedge clk_in);
		wr_out = 1'b0;
		idx_out = ~idx;
		wdata_out = ~data;
	endtask : wr_obj

	task automatic rd_obj(input logic [15:0] idx, output logic [15:0] data);
		bit got;
		got = 1'b0;
		data = 16'hxxxx;
		@(negedge clk_in);
		rd_out = 1'b1;
		idx_out = idx;
		@(negedge clk_in);
		rd_out = 1'b0;
		idx_out = ~idx;
		for (int i = 0; i < 3 && !got; i++) begin
			if (rvalid_in === 1'b1) begin
				data = rdata_in;
				got = 1'b1;
			end else begin
				@(negedge clk_in);
			end
		end
	endtask : rd_obj

	// state word is read before every state-change command
	task automatic command(input logic [15:0] data);
		logic [15:0] st;
		rd_obj(IDX_STATE_WORD, st);
		wr_obj(IDX_CMD_WORD, data);
	endtask : command
endmodule : dcwd_master_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the drive command word decoder
// assumes a short control cycle so each command settles within 16 clocks
`default_nettype none
module tb_top;
	import dcwd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CYC = 8;
	logic clk, nrst, fault_det, stopped, supply, prof;
	logic wr, rd, rvalid;
	logic [15:0] idx, wdata, rdata, stw, sw;
	logic stage, qs_ramp, hold, fstop, halt, nsp, rel, start, cancel;
	int fails, num_checks, cycles, starts, cancels;

	dcwd_decoder #(.CYCLE_CLKS(CYC)) DUT (
		.ref_clk_in(clk), .nrst_in(nrst), .obj_wr_in(wr), .obj_rd_in(rd),
		.obj_index_in(idx), .obj_wdata_in(wdata), .obj_rdata_out(rdata), .obj_rvalid_out(rvalid),
		.fault_detect_in(fault_det), .motor_stopped_in(stopped), .supply_ok_in(supply),
		.profile_pos_in(prof), .state_word_out(stw), .stage_enable_out(stage),
		.qs_ramp_out(qs_ramp), .hold_pos_out(hold), .fault_stop_out(fstop), .halt_out(halt),
		.new_setpoint_out(nsp), .relative_out(rel), .start_job_out(start), .cancel_jobs_out(cancel)
	);

	dcwd_master_model m (
		.clk_in(clk), .wr_out(wr), .rd_out(rd), .idx_out(idx), .wdata_out(wdata),
		.rdata_in(rdata), .rvalid_in(rvalid)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (start === 1'b1) starts <= starts + 1;
		if (cancel === 1'b1) cancels <= cancels + 1;
		cycles <= cycles + 1;
		// generous ceiling: the sequence needs well under a thousand clocks
		if (cycles == 5000) begin
			// blocking so the verdict below already sees the timeout
			fails = fails + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n * CYC) @(negedge clk);
	endtask : wait_cyc

	// issue a command, let two ticks pass, compare the state word
	task automatic go(input logic [15:0] cmd, input logic [15:0] exp);
		m.command(cmd);
		wait_cyc(2);
		m.rd_obj(IDX_STATE_WORD, sw);
		check(sw, exp);
	endtask : go

	initial begin
		fails = 0;
		num_checks = 0;
		cycles = 0;
		starts = 0;
		cancels = 0;
		nrst = 1'b0;
		fault_det = 1'b0;
		stopped = 1'b0;
		supply = 1'b1;
		prof = 1'b0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		wait_cyc(3);
		m.rd_obj(IDX_STATE_WORD, sw);
		check(sw, 16'h0040);
		m.rd_obj(IDX_CMD_WORD, sw);
		check(sw, CMD_WORD_RST);
		go(16'h0007, 16'h0040);
		go(16'h0006, 16'h0021);
		go(16'h0007, 16'h0023);
		supply = 1'b0;
		go(16'h000f, 16'h0023);
		supply = 1'b1;
		go(16'h000f, 16'h0037);
		go(16'h0007, 16'h0023);
		go(16'h000f, 16'h0037);
		go(16'h000b, 16'h0017);
		check({15'h0000, qs_ramp}, 16'h0001);
		stopped = 1'b1;
		prof = 1'b1;
		wait_cyc(2);
		check({15'h0000, hold}, 16'h0001);
		go(16'h000f, 16'h0017);
		go(16'h0000, 16'h0040);
		check({15'h0000, stage}, 16'h0000);
		go(16'h0006, 16'h0021);
		go(16'h800f, 16'h8037);
		go(16'hfe1f, 16'h8037);
		m.rd_obj(IDX_CMD_WORD, sw);
		check(sw, 16'hfe1f);
		check({15'h0000, nsp}, 16'h0001);
		check(starts[15:0], 16'h0001);
		go(16'h014f, 16'h0037);
		check({13'h0000, halt, rel, nsp}, 16'h0006);
		stopped = 1'b0;
		fault_det = 1'b1;
		wait_cyc(2);
		m.rd_obj(IDX_STATE_WORD, sw);
		check(sw, 16'h001f);
		check({15'h0000, fstop}, 16'h0001);
		stopped = 1'b1;
		fault_det = 1'b0;
		wait_cyc(2);
		m.rd_obj(IDX_STATE_WORD, sw);
		check(sw, 16'h0008);
		go(16'h0080, 16'h0040);
		fault_det = 1'b1;
		wait_cyc(3);
		fault_det = 1'b0;
		go(16'h0080, 16'h0008);
		go(16'h0000, 16'h0008);
		go(16'h0080, 16'h0040);
		m.wr_obj(IDX_STATE_WORD, 16'h1234);
		m.rd_obj(IDX_CMD_WORD, sw);
		check(sw, 16'h0080);
		go(16'h0006, 16'h0021);
		go(16'h000f, 16'h0037);
		go(16'h003f, 16'h0037);
		check(starts[15:0], 16'h0002);
		go(16'h0004, 16'h0040);
		check({15'h0000, stage}, 16'h0000);
		check(cancels[15:0], 16'h0004);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
